// File: core/ics_pkg.sv
// Package with register map, field layout, states and carriers of the two-wire slave interface.
package ics_pkg;

    // ------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------
    localparam int          APB_AW        = 12;
    localparam int          IDX_W         = 10;
    localparam logic [9:0]  IDX_ADDR_TWO  = 10'h091;
    localparam logic [9:0]  IDX_ADDR_THR  = 10'h092;
    localparam logic [9:0]  IDX_ADDR_FOUR = 10'h093;
    localparam logic [9:0]  IDX_CTRL      = 10'h098;
    localparam logic [9:0]  IDX_DATA      = 10'h09A;
    localparam logic [9:0]  IDX_ADDR_ONE  = 10'h09B;
    localparam logic [9:0]  IDX_IRQ_STAT  = 10'h09C;
    localparam logic [9:0]  IDX_IRQ_MASK  = 10'h09D;

    // ------------------------------------------------------------
    // Reset values and field positions.
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_ADDR_ONE  = 8'h55;
    localparam logic [7:0]  RST_ADDR_MORE = 8'h7F;
    localparam logic [7:0]  RST_DATA      = 8'h00;
    localparam int          CTRL_SRST     = 2;
    localparam int          CTRL_DIR      = 1;
    localparam int          CTRL_FLAG     = 0;
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_BYTE      = 0;
    localparam int          IRQ_ADDR      = 1;
    localparam int          IRQ_STOP      = 2;
    localparam int          NUM_ADDR      = 4;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_ACK    = 3'b010,
        ST_RX     = 3'b011,
        ST_TX     = 3'b100,
        ST_TXACK  = 3'b101,
        ST_TXLOAD = 3'b110
    } ics_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } ics_line_s;

    typedef struct packed {
        ics_state_e             state;
        logic [3:0]             cnt;
        logic [7:0]             shreg;
        logic                   nack;
        ics_line_s              line_prev;
        logic [NUM_ADDR-1:0][7:0] slave_addr;
        logic [7:0]             tx_data;
        logic [7:0]             rx_data;
        logic                   srst;
        logic                   dir;
        logic                   flag;
        logic [IRQ_W-1:0]       irq_stat;
        logic [IRQ_W-1:0]       irq_mask;
        logic                   irq;
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic                   scl_oe;
        logic                   sda_oe;
        logic                   scl_o;
        logic                   sda_o;
    } ics_st_s;

endpackage : ics_pkg

// File: core/ics_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ns
module ics_sync
    import ics_pkg::*;
#(
    parameter int W = 2
)(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '1;
            q      <= '1;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ics_sync

// File: core/ics_addr_cmp.sv
// Compare of a received 7-bit address with one slave address register.
`timescale 1ns/1ns
module ics_addr_cmp
    import ics_pkg::*;
(
    input  wire logic [7:0] slave_addr,
    input  wire logic [6:0] rx_addr,
    output logic            hit
);
    assign hit = (slave_addr[6:0] == rx_addr);
endmodule : ics_addr_cmp

// File: core/ics_slave.sv
// Two-wire serial slave interface with APB register access.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module ics_slave
    import ics_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    output logic                   irq
);

    // ------------------------------------------------------------
    // Pin sampling and bus events.
    // ------------------------------------------------------------
    ics_line_s             line;
    ics_st_s               s;
    ics_st_s               n;
    logic [NUM_ADDR-1:0]   hit_vec;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_ev;
    logic                  stop_ev;
    logic [IDX_W-1:0]      idx;
    logic                  xfer;
    logic                  mapped;
    logic                  data_acc;
    logic                  byte_set;
    logic                  addr_set;
    logic                  stop_set;
    logic [31:0]           rdata;

    ics_sync #(.W(2)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_i, sda_i}),
        .q     (line)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ADDR; gi++)
        begin : g_cmp
            ics_addr_cmp u_cmp (
                .slave_addr (s.slave_addr[gi]),
                .rx_addr    (s.shreg[7:1]),
                .hit        (hit_vec[gi])
            );
        end
    endgenerate

    // The interface is always clocked from pclk; the link clock is only sampled.
    assign scl_rise = line.scl & ~s.line_prev.scl;
    assign scl_fall = ~line.scl & s.line_prev.scl;
    assign start_ev = line.scl & s.line_prev.scl & s.line_prev.sda & ~line.sda;
    assign stop_ev  = line.scl & s.line_prev.scl & ~s.line_prev.sda & line.sda;

    assign idx      = paddr[APB_AW-1:2];
    assign xfer     = psel & penable & s.pready;
    assign data_acc = xfer & (idx == IDX_DATA);

    // ------------------------------------------------------------
    // Register read decode.
    // ------------------------------------------------------------
    always_comb
    begin
        rdata  = '0;
        mapped = 1'b1;
        case (idx)
            IDX_ADDR_ONE:  rdata[7:0] = s.slave_addr[0];
            IDX_ADDR_TWO:  rdata[7:0] = s.slave_addr[1];
            IDX_ADDR_THR:  rdata[7:0] = s.slave_addr[2];
            IDX_ADDR_FOUR: rdata[7:0] = s.slave_addr[3];
            IDX_DATA:      rdata[7:0] = s.rx_data;
            IDX_CTRL:
            begin
                rdata[CTRL_SRST] = s.srst;
                rdata[CTRL_DIR]  = s.dir;
                rdata[CTRL_FLAG] = s.flag;
            end
            IDX_IRQ_STAT:  rdata[IRQ_W-1:0] = s.irq_stat;
            IDX_IRQ_MASK:  rdata[IRQ_W-1:0] = s.irq_mask;
            default:       mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------
    always_comb
    begin
        n        = s;
        byte_set = 1'b0;
        addr_set = 1'b0;
        stop_set = 1'b0;
        n.line_prev = line;

        // APB answers one cycle after the access phase starts.
        n.pready = psel & penable & ~s.pready;
        if (psel & penable & ~s.pready)
        begin
            n.prdata  = rdata;
            n.pslverr = ~mapped;
        end

        if (xfer & pwrite & mapped)
        begin
            case (idx)
                IDX_ADDR_ONE:  n.slave_addr[0] = pwdata[7:0];
                IDX_ADDR_TWO:  n.slave_addr[1] = pwdata[7:0];
                IDX_ADDR_THR:  n.slave_addr[2] = pwdata[7:0];
                IDX_ADDR_FOUR: n.slave_addr[3] = pwdata[7:0];
                IDX_DATA:      n.tx_data       = pwdata[7:0];
                IDX_CTRL:      n.srst          = pwdata[CTRL_SRST];
                IDX_IRQ_MASK:  n.irq_mask      = pwdata[IRQ_W-1:0];
                default:       n.tx_data       = n.tx_data;
            endcase
        end

        // Serial engine; data only changes while the clock line is low.
        case (s.state)
            ST_ADDR, ST_RX:
            begin
                if (scl_rise)
                begin
                    n.shreg = {s.shreg[6:0], line.sda};
                    n.cnt   = s.cnt + 4'h1;
                end
                else if (scl_fall && s.cnt == BYTE_BITS)
                begin
                    n.cnt = '0;
                    if (s.state == ST_RX)
                    begin
                        n.rx_data = s.shreg;
                        n.dir     = 1'b0;
                        byte_set  = 1'b1;
                        n.sda_oe  = 1'b1;
                        n.state   = ST_ACK;
                    end
                    else if (|hit_vec)
                    begin
                        n.rx_data = s.shreg;
                        n.dir     = s.shreg[0];
                        byte_set  = 1'b1;
                        addr_set  = 1'b1;
                        n.sda_oe  = 1'b1;
                        n.state   = ST_ACK;
                    end
                    else
                    begin
                        n.state = ST_IDLE;
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    n.sda_oe = 1'b0;
                    n.cnt    = '0;
                    n.state  = s.dir ? ST_TXLOAD : ST_RX;
                end
            end
            ST_TXLOAD:
            begin
                if (!(s.flag & ~data_acc))
                begin
                    n.shreg  = n.tx_data;
                    n.sda_oe = ~n.tx_data[7];
                    n.cnt    = '0;
                    n.state  = ST_TX;
                end
            end
            ST_TX:
            begin
                if (scl_fall)
                begin
                    n.cnt = s.cnt + 4'h1;
                    if (s.cnt + 4'h1 == BYTE_BITS)
                    begin
                        n.sda_oe = 1'b0;
                        byte_set = 1'b1;
                        n.state  = ST_TXACK;
                    end
                    else
                    begin
                        n.shreg  = {s.shreg[6:0], 1'b0};
                        n.sda_oe = ~s.shreg[6];
                    end
                end
            end
            ST_TXACK:
            begin
                if (scl_rise)
                begin
                    n.nack = line.sda;
                end
                else if (scl_fall)
                begin
                    n.state = s.nack ? ST_IDLE : ST_TXLOAD;
                end
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase

        if (stop_ev)
        begin
            stop_set = (s.state != ST_IDLE);
            n.state  = ST_IDLE;
            n.sda_oe = 1'b0;
        end
        else if (start_ev)
        begin
            n.state  = ST_ADDR;
            n.cnt    = '0;
            n.sda_oe = 1'b0;
        end

        // Held in reset keeps the lines released and drops any transfer.
        if (s.srst)
        begin
            n.state  = ST_IDLE;
            n.cnt    = '0;
            n.sda_oe = 1'b0;
            byte_set = 1'b0;
            addr_set = 1'b0;
            stop_set = 1'b0;
        end

        // A byte event in the same cycle as a data access wins over the clear.
        n.flag = (s.flag & ~data_acc) | byte_set;
        n.irq_stat = s.irq_stat;
        n.irq_stat[IRQ_BYTE] = s.irq_stat[IRQ_BYTE] & ~data_acc;
        if (xfer & pwrite & (idx == IDX_IRQ_STAT))
        begin
            n.irq_stat = n.irq_stat & ~pwdata[IRQ_W-1:0];
        end
        n.irq_stat[IRQ_BYTE] = n.irq_stat[IRQ_BYTE] | byte_set;
        n.irq_stat[IRQ_ADDR] = n.irq_stat[IRQ_ADDR] | addr_set;
        n.irq_stat[IRQ_STOP] = n.irq_stat[IRQ_STOP] | stop_set;
        n.irq = |(s.irq_stat & s.irq_mask);

        // Stretching costs bus time but keeps a byte from being overrun.
        n.scl_oe = ((n.state == ST_ACK) | (n.state == ST_TXLOAD)) & n.flag;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s               <= '0;
            s.state         <= ST_IDLE;
            s.line_prev     <= '1;
            s.slave_addr[0] <= RST_ADDR_ONE;
            s.slave_addr[1] <= RST_ADDR_MORE;
            s.slave_addr[2] <= RST_ADDR_MORE;
            s.slave_addr[3] <= RST_ADDR_MORE;
            s.tx_data       <= RST_DATA;
            s.rx_data       <= RST_DATA;
        end
        else
        begin
            s <= n;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign scl_o   = s.scl_o;
    assign scl_oe  = s.scl_oe;
    assign sda_o   = s.sda_o;
    assign sda_oe  = s.sda_oe;
    assign irq     = s.irq;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_byte_in;
        s.state == ST_RX && scl_fall && s.cnt == BYTE_BITS && !stop_ev && !start_ev && !s.srst;
    endsequence

    sequence s_addr_in;
        s.state == ST_ADDR && scl_fall && s.cnt == BYTE_BITS && !stop_ev && !start_ev && !s.srst;
    endsequence

    a_soft_reset_idle: assert property (s.srst |=> s.state == ST_IDLE && !s.sda_oe)
        else $error("soft reset did not idle the serial side");
    a_dir_tracks_tx: assert property ((s.state == ST_TX) |-> s.dir)
        else $error("direction flag low while transmitting");
    a_dir_tracks_rx: assert property ((s.state == ST_RX) |-> !s.dir)
        else $error("direction flag high while receiving");
    a_byte_sets_flag: assert property (s_byte_in |=> s.flag && s.irq_stat[IRQ_BYTE])
        else $error("received byte did not set the flag");
    a_read_clears_flag: assert property (data_acc && !pwrite && !byte_set |=> !s.flag)
        else $error("data read did not clear the flag");
    a_write_clears_irq: assert property (data_acc && pwrite && !byte_set |=> !s.irq_stat[IRQ_BYTE])
        else $error("data write did not clear the byte interrupt");
    a_data_read_value: assert property (psel && penable && !s.pready && !pwrite && idx == IDX_DATA
        |=> s.pready && s.prdata == {24'h0, $past(s.rx_data)})
        else $error("data read returned wrong byte");
    a_addr_match_ack: assert property ((s_addr_in and (|hit_vec)) |=> s.state == ST_ACK && s.sda_oe)
        else $error("matched address not acknowledged");
    a_addr_miss_idle: assert property ((s_addr_in and !(|hit_vec)) |=> s.state == ST_IDLE && !s.sda_oe)
        else $error("unmatched address not ignored");
    a_stretch_hold: assert property (s_byte_in |=> s.scl_oe ##1 (s.scl_oe || !s.flag))
        else $error("clock line not held after byte");

endmodule : ics_slave

// File: verification/ics_bus_master.sv
// Behavioural two-wire bus master on the far side of the slave.
`timescale 1ns/1ns
module ics_bus_master
    import ics_pkg::*;
(
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    // ----------------------------------------------------------------
    // Line handling: zero pulls a line low, one lets the pull-up win.
    // ----------------------------------------------------------------
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // The slave may stretch the clock, so each rise waits for the line, but not for ever.
    task automatic wait_high;
        int n;
        n = 0;
        while (scl_line !== 1'b1 && n < 5000)
        begin
            #8;
            n++;
        end
    endtask : wait_high

    // Data moves well after the clock fell, so the slave never sees a false start or stop.
    task automatic xfer_bit(input logic b, output logic r);
        #10 sda_drv = b;
        #30 scl_drv = 1'b1;
        wait_high();
        #20 r = sda_line;
        #20 scl_drv = 1'b0;
    endtask : xfer_bit

    task automatic byte_xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xfer_bit(tx[i], r);
            rx = {rx[6:0], r};
        end
        xfer_bit(ack_in, ack_out);
    endtask : byte_xfer

    task automatic start_cond;
        sda_drv = 1'b1;
        scl_drv = 1'b1;
        #40 sda_drv = 1'b0;
        #40 scl_drv = 1'b0;
    endtask : start_cond

    // The clock is left high after a stop, so it stands still between frames.
    task automatic stop_cond;
        #10 sda_drv = 1'b0;
        #30 scl_drv = 1'b1;
        wait_high();
        #40 sda_drv = 1'b1;
        #40;
    endtask : stop_cond
endmodule : ics_bus_master

// File: verification/test_ics_slave.sv
// Self-checking testbench of the two-wire slave with register and link traffic.
`timescale 1ns/1ns
module test_ics_slave
    import ics_pkg::*;
;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              scl_o;
    logic              scl_oe;
    logic              sda_o;
    logic              sda_oe;
    logic              irq;
    logic              mst_scl;
    logic              mst_sda;
    wire logic         scl_line;
    wire logic         sda_line;
    int                err_count;
    int                samples_checked;

    // Both lines are open drain with pull-ups.
    assign scl_line = (scl_oe ? scl_o : 1'b1) & mst_scl;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & mst_sda;

    ics_slave dut_u (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .scl_i   (scl_line),
        .scl_o   (scl_o),
        .scl_oe  (scl_oe),
        .sda_i   (sda_line),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .irq     (irq)
    );

    ics_bus_master mst_u (
        .scl_line (scl_line),
        .sda_line (sda_line),
        .scl_drv  (mst_scl),
        .sda_drv  (mst_sda)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check("apb answer", 32'h1, {31'h0, pready});
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0, rd, err);
        check(what, exp, rd);
    endtask : rd_chk

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        check("irq raised", 32'h1, {31'h0, irq});
    endtask : wait_irq

    // Software side of one received byte; the data register is touched once.
    task automatic serve_rx(input logic [7:0] exp, input logic [31:0] stat);
        wait_irq();
        check("clock stretched", 32'h1, {31'h0, scl_oe});
        rd_chk(IDX_CTRL, 32'h1, "ctrl receiving");
        rd_chk(IDX_DATA, {24'h0, exp}, "received byte");
        rd_chk(IDX_CTRL, 32'h0, "flag after read");
        rd_chk(IDX_IRQ_STAT, stat, "irq status");
        check("irq after read", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_STAT, 32'h2);
    endtask : serve_rx

    task automatic write_xfer(input logic [6:0] adr, input logic [7:0] dat);
        logic [7:0] rx;
        logic       ack;
        wr(IDX_IRQ_STAT, 32'h7);
        mst_u.start_cond();
        fork
            mst_u.byte_xfer({adr, 1'b0}, 1'b1, rx, ack);
            serve_rx({adr, 1'b0}, 32'h2);
        join
        check("address ack", 32'h0, {31'h0, ack});
        fork
            mst_u.byte_xfer(dat, 1'b1, rx, ack);
            serve_rx(dat, 32'h0);
        join
        check("data ack", 32'h0, {31'h0, ack});
        mst_u.stop_cond();
    endtask : write_xfer

    task automatic read_xfer(input logic [6:0] adr, input logic [7:0] dat);
        logic [7:0] rx;
        logic       ack;
        mst_u.start_cond();
        fork
            mst_u.byte_xfer({adr, 1'b1}, 1'b1, rx, ack);
            begin
                wait_irq();
                rd_chk(IDX_CTRL, 32'h3, "ctrl sending");
                wr(IDX_DATA, {24'h0, dat});
                rd_chk(IDX_CTRL, 32'h2, "flag after write");
                check("irq after write", 32'h0, {31'h0, irq});
            end
        join
        check("read address ack", 32'h0, {31'h0, ack});
        mst_u.byte_xfer(8'hFF, 1'b1, rx, ack);
        check("sent byte", {24'h0, dat}, {24'h0, rx});
        // The sent byte raises the flag too; it must be serviced or the next frame sees a stale event.
        wait_irq();
        rd_chk(IDX_CTRL, 32'h3, "ctrl after sent byte");
        rd_chk(IDX_DATA, {24'h0, adr, 1'b1}, "data after sent byte");
        mst_u.stop_cond();
    endtask : read_xfer

    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic        err;
        logic [6:0]  adr [4];
        logic [7:0]  rx;
        logic        ack;
        err_count = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        void'($urandom(32'h55BE));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(IDX_ADDR_ONE, {24'h0, RST_ADDR_ONE}, "addr one reset");
        for (int i = 0; i < 3; i++)
            rd_chk(IDX_ADDR_TWO + 10'(i), {24'h0, RST_ADDR_MORE}, "addr reset");
        rd_chk(IDX_DATA, {24'h0, RST_DATA}, "data reset");
        apb(1'b0, 10'h0A0, 32'h0, rd, err);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test reset values done");
        wr(IDX_IRQ_MASK, 32'h1);
        adr[0] = {3'h5, 4'($urandom)};
        wr(IDX_ADDR_ONE, {25'h0, adr[0]});
        rd_chk(IDX_ADDR_ONE, {25'h0, adr[0]}, "addr one write");
        for (int i = 1; i < 4; i++)
        begin
            adr[i] = {3'(i), 4'($urandom)};
            wr(IDX_ADDR_TWO + 10'(i - 1), {25'h0, adr[i]});
            rd_chk(IDX_ADDR_TWO + 10'(i - 1), {25'h0, adr[i]}, "addr write");
        end
        for (int i = 0; i < 4; i++)
            write_xfer(adr[i], 8'($urandom));
        $display("test write transfers done");
        read_xfer(adr[1], 8'($urandom));
        read_xfer(adr[3], 8'h00);
        $display("test read transfers done");
        mst_u.start_cond();
        mst_u.byte_xfer({3'h6, 4'($urandom), 1'b0}, 1'b1, rx, ack);
        check("foreign address ack", 32'h1, {31'h0, ack});
        mst_u.stop_cond();
        // The direction bit keeps its value from the last read transfer while the bus is idle.
        rd_chk(IDX_CTRL, 32'h2, "no flag on foreign address");
        $display("test foreign address done");
        wr(IDX_CTRL, 32'h7);
        rd_chk(IDX_CTRL, 32'h6, "soft reset set");
        mst_u.start_cond();
        mst_u.byte_xfer({adr[0], 1'b0}, 1'b1, rx, ack);
        check("ack in soft reset", 32'h1, {31'h0, ack});
        mst_u.stop_cond();
        wr(IDX_CTRL, 32'h0);
        write_xfer(adr[0], 8'($urandom));
        $display("test soft reset done");
        close_out();
    end

    // The whole run takes about 15 us; the limit leaves a wide margin.
    initial
    begin
        #400000;
        err_count++;
        close_out();
    end
endmodule : test_ics_slave
